/* File: src/coil_pkg.sv */
// shared constants and types for the voice coil current and power mode controller
package coil_pkg;
  localparam int CLK_HZ      = 50_000_000;
  localparam int CLK_KHZ     = CLK_HZ / 1000;
  localparam int CLK_PER_US  = CLK_HZ / 1_000_000;
  localparam int SDN_LOW_US  = 500;                     // 0.5 ms of scl low
  localparam int SDN_CYC     = SDN_LOW_US * CLK_PER_US; // least time
  localparam int WAKE_US     = 100;
  localparam int WAKE_CYC    = WAKE_US * CLK_PER_US;    // longest time
  localparam int WAKE_LAT    = 4;                       // wake latency bound; the logic wakes 3 clocks after scl rises
  localparam int FSW_MIN_KHZ = 500;
  localparam int FSW_MAX_KHZ = 4000;
  localparam int PWM_PER0    = CLK_KHZ / FSW_MIN_KHZ;   // 100 cycles at select 0
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_DIV_CYC = RAMP_STEP_NS * CLK_KHZ / 1_000_000;
  localparam int DAC_W       = 10;
  localparam int FSEL_W      = 2;
  localparam int ST_W        = 3;

  localparam logic [7:0] OFF_SETPT  = 8'h00;
  localparam logic [7:0] OFF_MODE   = 8'h04;
  localparam logic [7:0] OFF_CTRL   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MASK   = 8'h10;
  localparam logic [7:0] OFF_STATE  = 8'h14;

  localparam int MODE_PWM_BIT  = 0;
  localparam int CTRL_FSEL_LSB = 0;
  localparam int ST_SHORT      = 0;
  localparam int ST_RAMP       = 1;
  localparam int ST_WAKE       = 2;
  localparam int STATE_PWR_LSB = 0;
  localparam int STATE_RMP_LSB = 4;

  localparam logic              MODE_RST   = 1'b0;
  localparam logic [FSEL_W-1:0] FSEL_RST   = 2'h0;
  localparam logic [ST_W-1:0]   MASK_RST   = 3'h0;
  localparam logic [ST_W-1:0]   STATUS_RST = 3'h0;

  typedef enum logic [1:0] {PWR_SDN, PWR_STBY, PWR_ACT} pwr_t;

  typedef struct packed {
    logic out_en;
    logic hs_on;
    logic ls_on;
    logic lin_en;
  } drive_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
  } ahb_req_t;
endpackage

/* File: src/coil_current_power_mode_ctrl.sv */
// power sequencing, setpoint ramp, drive generation and ahb-lite registers of the coil driver
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module coil_current_power_mode_ctrl #(
  parameter int SHUTDOWN_CYCLES = coil_pkg::SDN_CYC,
  parameter int WAKE_CYCLES     = coil_pkg::WAKE_CYC,
  parameter int RAMP_DIV        = coil_pkg::RAMP_DIV_CYC,
  parameter int DAC_W           = coil_pkg::DAC_W
) (
  input  wire logic             CLK_SYS,
  input  wire logic             RST_B,
  input  wire logic             SCL_IN,
  input  wire logic             ILIM_TRIP,
  input  wire logic             HSEL,
  input  wire logic [31:0]      HADDR,
  input  wire logic [1:0]       HTRANS,
  input  wire logic             HWRITE,
  input  wire logic [2:0]       HSIZE,
  input  wire logic [31:0]      HWDATA,
  input  wire logic             HREADY,
  output logic                  HREADYOUT,
  output logic                  HRESP,
  output logic [31:0]           HRDATA,
  output logic                  IRQ,
  output coil_pkg::drive_t      DRIVE,
  output logic [DAC_W-1:0]      DAC_CODE,
  output coil_pkg::pwr_t        PWR_STATE
);
  localparam int CW = $clog2(SHUTDOWN_CYCLES + 1);
  localparam int DW = $clog2(RAMP_DIV + 1);
  localparam int ST = coil_pkg::ST_W;
  if (SHUTDOWN_CYCLES < 2 || WAKE_CYCLES < coil_pkg::WAKE_LAT || RAMP_DIV < 1
      || DAC_W < 4 || DAC_W > 16)
  begin : g_chk
    $error("coil_current_power_mode_ctrl: unsupported parameter value");
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0]          scl_sync;
  logic [1:0]          ilim_sync;
  logic                scl_prev;
  logic [CW-1:0]       low_cnt;
  coil_pkg::pwr_t      state;
  coil_pkg::pwr_t      next_state;
  logic [DAC_W-1:0]    setpt;
  logic [DAC_W-1:0]    ramp;
  logic                pwm_mode;
  logic [coil_pkg::FSEL_W-1:0] fsel;
  logic [ST-1:0]       status;
  logic [ST-1:0]       mask;
  wire scl      = scl_sync[1];
  wire ilim     = ilim_sync[1];
  wire scl_rise = scl & ~scl_prev;
  wire low_to   = (low_cnt == CW'(SHUTDOWN_CYCLES));
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      scl_sync  <= 2'h0;
      ilim_sync <= 2'h0;
      scl_prev  <= 1'b0;
    end
    else
    begin
      scl_sync  <= {scl_sync[0], SCL_IN};
      ilim_sync <= {ilim_sync[0], ILIM_TRIP};
      scl_prev  <= scl;
    end
  end

  // saturating count of consecutive low cycles on scl
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      low_cnt <= '0;
    else if (scl)
      low_cnt <= '0;
    else if (!low_to)
      low_cnt <= low_cnt + 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // power state machine
  wire wake     = (state == coil_pkg::PWR_SDN) && scl_rise;
  wire short_ev = (state == coil_pkg::PWR_ACT) && ilim;
  always_comb
  begin
    next_state = state;
    case (state)
      coil_pkg::PWR_SDN:
        if (scl_rise)
          next_state = coil_pkg::PWR_STBY;
      coil_pkg::PWR_STBY:
        if (low_to)
          next_state = coil_pkg::PWR_SDN;
        else if (setpt != '0 && !ilim)
          next_state = coil_pkg::PWR_ACT;
      coil_pkg::PWR_ACT:
        if (low_to)
          next_state = coil_pkg::PWR_SDN;
        else if (ilim || setpt == '0)
          next_state = coil_pkg::PWR_STBY;
      default:
        next_state = coil_pkg::PWR_SDN;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      state <= coil_pkg::PWR_SDN;
    else
      state <= next_state;
  end

  //////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait on writes, one wait state on reads
  coil_pkg::ahb_req_t req;
  logic               rd_done;
  wire ahb_sel  = HSEL & HREADY & HTRANS[1];
  wire rd_phase = req.rd & ~rd_done;
  wire wr_ok    = req.wr && state != coil_pkg::PWR_SDN;
  wire wr_setpt = wr_ok && req.addr == coil_pkg::OFF_SETPT;
  wire wr_mode  = wr_ok && req.addr == coil_pkg::OFF_MODE;
  wire wr_ctrl  = wr_ok && req.addr == coil_pkg::OFF_CTRL;
  wire wr_stat  = wr_ok && req.addr == coil_pkg::OFF_STATUS;
  wire wr_mask  = wr_ok && req.addr == coil_pkg::OFF_MASK;
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (req.addr)
      coil_pkg::OFF_SETPT:  rd_mux[DAC_W-1:0] = setpt;
      coil_pkg::OFF_MODE:   rd_mux[coil_pkg::MODE_PWM_BIT] = pwm_mode;
      coil_pkg::OFF_CTRL:   rd_mux[coil_pkg::CTRL_FSEL_LSB +: coil_pkg::FSEL_W] = fsel;
      coil_pkg::OFF_STATUS: rd_mux[ST-1:0] = status;
      coil_pkg::OFF_MASK:   rd_mux[ST-1:0] = mask;
      coil_pkg::OFF_STATE:
      begin
        rd_mux[coil_pkg::STATE_PWR_LSB +: 2]     = state;
        rd_mux[coil_pkg::STATE_RMP_LSB +: DAC_W] = ramp;
      end
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      req     <= '0;
      rd_done <= 1'b0;
      HRDATA  <= 32'h0000_0000;
    end
    else
    begin
      if (HREADYOUT)
      begin
        req     <= ahb_sel ? coil_pkg::ahb_req_t'{wr: HWRITE, rd: ~HWRITE, addr: HADDR[7:0]} : '0;
        rd_done <= 1'b0;
      end
      if (rd_phase)
      begin
        HRDATA  <= rd_mux;
        rd_done <= 1'b1;
      end
    end
  end

  assign HREADYOUT = ~rd_phase;
  assign HRESP     = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // registers; a wake from shutdown reloads every default except the status bits
  logic [ST-1:0] events;
  logic          arrived_q;
  wire           arrived = (ramp == setpt) && state == coil_pkg::PWR_ACT;
  assign events = ST'({wake, arrived & ~arrived_q, short_ev} << coil_pkg::ST_SHORT);
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      setpt <= '0;
    else if (wake || short_ev)
      setpt <= '0;
    else if (wr_setpt)
      setpt <= HWDATA[DAC_W-1:0];
  end

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pwm_mode <= coil_pkg::MODE_RST;
      fsel     <= coil_pkg::FSEL_RST;
      mask     <= coil_pkg::MASK_RST;
    end
    else if (wake)
    begin
      pwm_mode <= coil_pkg::MODE_RST;
      fsel     <= coil_pkg::FSEL_RST;
      mask     <= coil_pkg::MASK_RST;
    end
    else
    begin
      if (wr_mode)
        pwm_mode <= HWDATA[coil_pkg::MODE_PWM_BIT];
      if (wr_ctrl)
        fsel <= HWDATA[coil_pkg::CTRL_FSEL_LSB +: coil_pkg::FSEL_W];
      if (wr_mask)
        mask <= HWDATA[ST-1:0];
    end
  end

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
      status <= coil_pkg::STATUS_RST;
    else
      status <= (status & ~(wr_stat ? HWDATA[ST-1:0] : '0)) | events;
  end

  assign IRQ = |(status & mask);

  //////////////////////////////////////////////////////////////////////////////
  // setpoint ramp, one lsb per divider pulse; this code feeds the converter
  logic [DW-1:0] div_cnt;
  wire           step_en = (div_cnt == DW'(RAMP_DIV - 1));
  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      div_cnt   <= '0;
      ramp      <= '0;
      arrived_q <= 1'b0;
    end
    else
    begin
      div_cnt   <= step_en ? '0 : div_cnt + 1'b1;
      arrived_q <= arrived;
      if (state != coil_pkg::PWR_ACT)
        ramp <= '0;
      else if (step_en && ramp < setpt)
        ramp <= ramp + 1'b1;
      else if (step_en && ramp > setpt)
        ramp <= ramp - 1'b1;
    end
  end

  assign DAC_CODE = ramp;

  //////////////////////////////////////////////////////////////////////////////
  // pwm: period halves per select step, high side leads each period
  logic [6:0]       pwm_cnt;
  logic [6:0]       per;
  logic [DAC_W+6:0] prod;
  coil_pkg::drive_t next_drive;
  assign per  = 7'(coil_pkg::PWM_PER0 >> fsel);
  assign prod = ramp * per;
  wire pwm_run = (state == coil_pkg::PWR_ACT) && pwm_mode;
  wire duty_hi = prod[DAC_W+6:DAC_W] > pwm_cnt;
  wire act     = (state == coil_pkg::PWR_ACT);
  assign next_drive = '{out_en: act,
                        hs_on:  pwm_run & duty_hi,
                        ls_on:  pwm_run & ~duty_hi,
                        lin_en: act & ~pwm_mode};

  always_ff @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pwm_cnt <= '0;
      DRIVE   <= '0;
    end
    else
    begin
      pwm_cnt <= (!pwm_run || pwm_cnt >= per - 1'b1) ? '0 : pwm_cnt + 1'b1;
      DRIVE   <= next_drive;
    end
  end

  assign PWR_STATE = state;

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  sequence zero_written;
    act && wr_setpt && HWDATA[DAC_W-1:0] == '0 && !ilim && !low_to;
  endsequence

  sequence lin_settled;
    (act && !pwm_mode && ramp == setpt)[*3];
  endsequence

  sdn_entry_a: assert property ((state != coil_pkg::PWR_SDN && low_to)
    |=> state == coil_pkg::PWR_SDN) else $error("no shutdown after scl low");
  sdn_cause_a: assert property ($rose(state == coil_pkg::PWR_SDN)
    |-> $past(low_cnt) == CW'(SHUTDOWN_CYCLES)) else $error("early shutdown");
  wake_dflt_a: assert property (wake |=> state == coil_pkg::PWR_STBY
    && setpt == '0 && pwm_mode == coil_pkg::MODE_RST && mask == coil_pkg::MASK_RST)
    else $error("wake did not restore defaults");
  act_entry_a: assert property ((state == coil_pkg::PWR_STBY && setpt != '0
    && !ilim && !low_to) |=> act ##1 DRIVE.out_en) else $error("active not entered");
  ramp_step_a: assert property (act && $past(act) |-> ramp == $past(ramp)
    || ramp == $past(ramp) + 1'b1 || ramp == $past(ramp) - 1'b1)
    else $error("ramp jumped");
  drive_style_a: assert property (DRIVE.lin_en |-> !DRIVE.hs_on
    && !DRIVE.ls_on) else $error("linear and pwm driven together");
  pwm_wrap_a: assert property ((pwm_run && pwm_cnt == per - 1'b1 && $stable(fsel))
    |=> pwm_cnt == '0) else $error("pwm period wrong");
  lin_level_a: assert property (lin_settled |=> DAC_CODE == $past(setpt)
    || !act) else $error("linear level off setpoint");
  hs_first_a: assert property ((pwm_run && pwm_cnt != '0 && duty_hi
    && $stable(ramp) && $stable(fsel)) |-> $past(duty_hi))
    else $error("high side after freewheel");
  read_wait_a: assert property ((ahb_sel && !HWRITE) |=> !HREADYOUT
    ##1 HREADYOUT) else $error("read answer timing");
  dac_track_a: assert property ((act && ramp == setpt) |=> DAC_CODE
    == $past(setpt) || setpt != $past(setpt) || !act) else $error("dac left setpoint");
  short_stby_a: assert property (short_ev |=> state == coil_pkg::PWR_STBY
    && status[coil_pkg::ST_SHORT] ##1 !DRIVE.out_en) else $error("short not handled");
  zero_stby_a: assert property (zero_written |=> setpt == '0
    ##1 state == coil_pkg::PWR_STBY ##1 !DRIVE.out_en) else $error("zero not standby");
endmodule

/* File: dv/scl_host_model.sv */
// serial clock line host model: idle high, held low, or clocking
`timescale 1ns/1ps
module scl_host_model #(
  parameter int HALF = 62
) (
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  output logic            scl
);
  int cnt = 0;

  // clocking near 400 kHz keeps every low phase far below the shutdown time
  always @(posedge clk)
  begin
    cnt <= (cnt >= HALF - 1) ? 0 : cnt + 1;
    if (mode == 2'h1)
      scl <= 1'b0; // line parked low asks for shutdown
    else if (mode == 2'h0)
      scl <= 1'b1; // released line sits at its pull-up level
    else if (cnt == HALF - 1)
      scl <= ~scl;
  end
endmodule

/* File: dv/tb_top.sv */
// self-checking bench of the coil current and power mode controller
`timescale 1ns/1ps
module tb_top;
  localparam int SDN  = 100;
  localparam int RDIV = 2;

  logic              clk_sys;
  logic              rst_b;
  logic              ilim_trip;
  logic              hsel;
  logic [31:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [31:0]       hwdata;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       hrdata;
  logic              irq;
  logic              scl;
  logic [1:0]        scl_mode;
  logic [31:0]       d;
  coil_pkg::drive_t  drive;
  logic [9:0]        dac;
  coil_pkg::pwr_t    pwr;
  int                miscompares = 0;
  int                tests_run = 0;
  int                cycles = 0;
  int                n;

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  scl_host_model host (.clk(clk_sys), .mode(scl_mode), .scl(scl));

  coil_current_power_mode_ctrl #(.SHUTDOWN_CYCLES(SDN), .RAMP_DIV(RDIV)) DUT (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .SCL_IN(scl), .ILIM_TRIP(ilim_trip),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp),
    .HRDATA(hrdata), .IRQ(irq), .DRIVE(drive), .DAC_CODE(dac), .PWR_STATE(pwr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    d = hrdata;
    chk(d, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wait_pwr(input coil_pkg::pwr_t s, input int lim);
    n = 0;
    while (pwr !== s && n < lim)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk({30'h0, pwr}, {30'h0, s});
  endtask

  // the ramp may move one code per cycle at most and must land on the target
  task automatic ramp_chk(input logic [9:0] tgt, input int lim);
    logic [9:0] prev;
    int         k;
    int         jumps;
    prev = dac;
    k = 0;
    jumps = 0;
    while (dac !== tgt && k < lim)
    begin
      @(posedge clk_sys);
      k++;
      if (dac > prev + 10'h1 || prev > dac + 10'h1)
        jumps++;
      prev = dac;
    end
    chk({22'h0, dac}, {22'h0, tgt});
    chk(32'(jumps), 32'h0);
  endtask

  // one switching period measured between two rises of the high-side switch
  task automatic pwm_chk(input int per);
    int hi;
    int lo;
    int k;
    repeat (110) @(posedge clk_sys);
    while (drive.hs_on !== 1'b0) @(posedge clk_sys);
    while (drive.hs_on !== 1'b1) @(posedge clk_sys);
    hi = 1;
    lo = 0;
    k = 0;
    @(posedge clk_sys);
    while (!(drive.hs_on === 1'b1 && lo > 0) && k < 200)
    begin
      if (drive.hs_on === 1'b1)
        hi++;
      else if (drive.ls_on === 1'b1)
        lo++;
      k++;
      @(posedge clk_sys);
    end
    chk(32'(k + 1), 32'(per));
    chk(32'(hi), 32'((512 * per) >> 10));
    chk(32'(hi + lo), 32'(per));
  endtask

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b = 1'b0;
    ilim_trip = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    scl_mode = 2'h1;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    wr(coil_pkg::OFF_SETPT, 32'h5);
    repeat (4) @(posedge clk_sys);
    chk({30'h0, pwr}, {30'h0, coil_pkg::PWR_SDN});
    $display("test shutdown after reset done");
    scl_mode <= 2'h0;
    wait_pwr(coil_pkg::PWR_STBY, coil_pkg::WAKE_CYC);
    rchk(coil_pkg::OFF_STATUS, 32'h4);
    rchk(coil_pkg::OFF_SETPT, 32'h0);
    wr(coil_pkg::OFF_MASK, 32'h7);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    wr(coil_pkg::OFF_STATUS, 32'h4);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rchk(8'h20, 32'h0);
    $display("test wake and interrupt done");
    scl_mode <= 2'h2;
    wr(coil_pkg::OFF_SETPT, 32'h8);
    wait_pwr(coil_pkg::PWR_ACT, 4);
    ramp_chk(10'h8, 100);
    repeat (3) @(posedge clk_sys);
    chk({28'h0, drive}, 32'h9);
    rchk(coil_pkg::OFF_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(coil_pkg::OFF_STATUS, 32'h2);
    $display("test linear drive and ramp done");
    wr(coil_pkg::OFF_MODE, 32'h1);
    wr(coil_pkg::OFF_SETPT, 32'h200);
    ramp_chk(10'h200, 1500);
    for (int f = 0; f < 4; f++)
    begin
      wr(coil_pkg::OFF_CTRL, 32'(f));
      pwm_chk(100 >> f);
    end
    chk({31'h0, drive.lin_en}, 32'h0);
    ramp_chk(10'h200, 4);
    $display("test pwm drive done");
    wr(coil_pkg::OFF_SETPT, 32'h0);
    wait_pwr(coil_pkg::PWR_STBY, 4);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, drive.out_en}, 32'h0);
    wr(coil_pkg::OFF_SETPT, 32'h8);
    wait_pwr(coil_pkg::PWR_ACT, 4);
    ilim_trip <= 1'b1;
    @(posedge clk_sys);
    wait_pwr(coil_pkg::PWR_STBY, 6);
    ilim_trip <= 1'b0;
    rchk(coil_pkg::OFF_SETPT, 32'h0);
    rchk(coil_pkg::OFF_STATUS, 32'h3);
    chk({31'h0, d[0]}, 32'h1);
    $display("test standby returns done");
    // line high first so the low time counts from the park, not from a clock low phase
    scl_mode <= 2'h0;
    repeat (6) @(posedge clk_sys);
    scl_mode <= 2'h1;
    @(posedge clk_sys);
    wait_pwr(coil_pkg::PWR_SDN, SDN + 10);
    chk(32'(n >= SDN - 1), 32'h1);
    scl_mode <= 2'h0;
    wait_pwr(coil_pkg::PWR_STBY, coil_pkg::WAKE_CYC);
    rchk(coil_pkg::OFF_MODE, 32'h0);
    rchk(coil_pkg::OFF_CTRL, 32'h0);
    rchk(coil_pkg::OFF_MASK, 32'h0);
    $display("test shutdown and register defaults done");
    end_of_test();
  end
endmodule
